/* shared/spow_consts.svh */
// Purpose: named offsets, fields, reset values and counts of the serial port
// Assumes: 8-bit register address and data on the plain register port
// Notes:   definitions only, no logic
`ifndef SPOW_CONSTS_SVH
`define SPOW_CONSTS_SVH
// register addresses
`define SPOW_ADR_PWR_BAUD   8'h87
`define SPOW_ADR_OPTION     8'h94
`define SPOW_ADR_CTRL       8'h98
`define SPOW_ADR_DATA       8'h99
`define SPOW_ADR_T1_RELOAD  8'h8D
`define SPOW_ADR_T2_CLKSEL  8'hC8
`define SPOW_ADR_T2_RLD_LO  8'hCA
`define SPOW_ADR_T2_RLD_HI  8'hCB
`define SPOW_ADR_IRQ_STAT   8'hE0
`define SPOW_ADR_IRQ_MASK   8'hE1
// field positions
`define SPOW_BIT_BAUD_DBL   3'h7
`define SPOW_BIT_ONE_WIRE   3'h7
`define SPOW_BIT_MODE_HI    3'h7
`define SPOW_BIT_MODE_LO    3'h6
`define SPOW_BIT_MPROC      3'h5
`define SPOW_BIT_RX_EN      3'h4
`define SPOW_BIT_TX_NINTH   3'h3
`define SPOW_BIT_RX_NINTH   3'h2
`define SPOW_BIT_TX_DONE    3'h1
`define SPOW_BIT_RX_DONE    3'h0
`define SPOW_BIT_RX_CLK_SEL 3'h5
`define SPOW_BIT_TX_CLK_SEL 3'h4
`define SPOW_IRQ_TX         1'h0
`define SPOW_IRQ_RX         1'h1
// reset values and counts
`define SPOW_RST_BYTE       8'h00
`define SPOW_OVS_LAST       4'hF
`define SPOW_OVS_MID        4'h7
`define SPOW_LAST_BIT       4'h7
`define SPOW_T1_TOP         8'hFF
`define SPOW_T2_TOP         16'hFFFF
`endif

/* shared/spow_pkg.sv */
// Purpose: types of the serial port with single-pin option
// Assumes: one clock domain
// Notes:   all state of the top module is one packed struct
package spow_pkg;
   typedef enum logic [1:0] {
      MODE_SHIFT  = 2'h0,
      MODE_UART8  = 2'h1,
      MODE_UART9F = 2'h2,
      MODE_UART9V = 2'h3
   } spow_mode_type;
   typedef enum logic [5:0] {
      TX_IDLE  = 6'h01,
      TX_START = 6'h02,
      TX_DATA  = 6'h04,
      TX_NINTH = 6'h08,
      TX_STOP  = 6'h10,
      TX_SHIFT = 6'h20
   } spow_tx_state_type;
   typedef enum logic [5:0] {
      RX_IDLE  = 6'h01,
      RX_START = 6'h02,
      RX_DATA  = 6'h04,
      RX_NINTH = 6'h08,
      RX_STOP  = 6'h10,
      RX_SHIFT = 6'h20
   } spow_rx_state_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } spow_bus_req_type;
   typedef struct packed {
      logic txd_i;
      logic rxd_i;
   } spow_pins_in_type;
   typedef struct packed {
      logic txd_o;
      logic txd_oe_n;
      logic rxd_o;
      logic rxd_oe_n;
   } spow_pins_out_type;
   typedef struct packed {
      logic [7:0]        rd_data;
      logic              irq;
      spow_pins_out_type pins;
      logic [3:0]        pwr_low;
      logic              baud_dbl;
      logic [7:0]        option;
      logic [7:0]        ctrl;
      logic [7:0]        rx_buf;
      logic [7:0]        t1_reload;
      logic [7:0]        t1_cnt;
      logic [15:0]       t2_reload;
      logic [15:0]       t2_cnt;
      logic              rx_clk_sel;
      logic              tx_clk_sel;
      logic              prescale;
      logic              t1_half;
      logic              m2_half;
      spow_tx_state_type tx_st;
      logic [8:0]        tx_sh;
      logic [3:0]        tx_bit;
      logic [3:0]        tx_sub;
      spow_rx_state_type rx_st;
      logic [8:0]        rx_sh;
      logic [3:0]        rx_bit;
      logic [3:0]        rx_sub;
      logic [1:0]        txd_sync;
      logic [1:0]        rxd_sync;
      logic              line_prev;
      logic [1:0]        irq_stat;
      logic [1:0]        irq_mask;
   } spow_state_type;
endpackage

/* rtl/spow_serial_port.sv */
// Purpose: serial port, shift and 8/9-bit UART modes, single-pin option
// Assumes: ref_clk is the system clock; pins are asynchronous and synchronised here
// Notes:   baud timers auto reload; a timer1 reload write or a timer2 high-byte reload write restarts the count
// Operation
// - data address: writes feed transmitter, reads return last received byte
// - single-pin bit set: UART transmit and receive share the tx pin; shift mode ignores it
// - mode field picks shift register, 8-bit UART, fixed or variable 9-bit UART
// - fixed-rate 9-bit mode runs at clock/64, or clock/32 when doubled
// - doubling bit doubles the rate of the modes that depend on it
// - timer1 source rate is (doubling+1) * clock / (64 * (256 - reload))
// - timer2 source rate is overflow/16 = clock / (32 * (65536 - reload))
// - 9-bit modes with multiprocessor bit: no receive flag when ninth bit 0
// - 8-bit UART with multiprocessor bit: receive flag only on valid stop
// - 9-bit modes send the transmit ninth bit as ninth data bit
// - ninth bit stored in 9-bit modes, stop bit stored in 8-bit UART
// - transmit flag set after eighth bit in shift mode, else at stop start
// - receive flag set after eighth bit in shift mode, else at stop sample
// - receiver in 8-bit and variable 9-bit UART uses timer2 overflow when receive select set, else timer1
// - transmitter in 8-bit and variable 9-bit UART uses timer2 overflow when transmit select set, else timer1
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "spow_consts.svh"

module spow_serial_port (
   input  wire logic                       ref_clk,  // system clock, 100 MHz
   input  wire logic                       rst_n,    // async reset, active low
   input  wire spow_pkg::spow_bus_req_type bus_req,  // register port request
   output      logic [7:0]                 rd_data,  // read data, cycle after read
   output      logic                       irq,      // level interrupt
   input  wire spow_pkg::spow_pins_in_type pins_in,  // raw pin levels
   output      spow_pkg::spow_pins_out_type pins_out // pin drive and enables
);
   import spow_pkg::*;

   spow_state_type state_ff;
   spow_state_type nxt_state;
   spow_mode_type  mode;
   logic           mode9;
   logic           one_wire;
   logic           tick2;
   logic           t1_ovf;
   logic           t2_ovf;
   logic           t1_16;
   logic           m2_16;
   logic           tx_tick;
   logic           rx_tick;
   logic           line_in;
   logic           tx_load;
   logic           tx_evt;
   logic           rx_evt;
   logic           stat_clr;
   logic [8:0]     sh_new;
   logic [7:0]     rx_data;
   logic           rx_ninth;
   logic           rx_accept;

   localparam spow_state_type RESET_STATE = '{
      pins:    '{txd_o: 1'b1, txd_oe_n: 1'b0, rxd_o: 1'b1, rxd_oe_n: 1'b1},
      tx_st:   TX_IDLE,
      rx_st:   RX_IDLE,
      default: '0
   };

   // oversample tick choice; same decode serves both directions
   function automatic logic sel_tick(input spow_mode_type m, input logic use_t2,
                                     input logic fixed_tick, input logic t2_tick,
                                     input logic t1_tick);
      logic r;
      r = 1'b0;
      if (m == MODE_UART9F) begin
         r = fixed_tick;
      end else if (use_t2) begin
         r = t2_tick;
      end else begin
         r = t1_tick;
      end
      return r;
   endfunction

   // next state of the whole port
   always_comb begin
      nxt_state = state_ff;
      nxt_state.rd_data = `SPOW_RST_BYTE;
      mode     = spow_mode_type'(state_ff.ctrl[`SPOW_BIT_MODE_HI:`SPOW_BIT_MODE_LO]);
      mode9    = state_ff.ctrl[`SPOW_BIT_MODE_HI];
      one_wire = state_ff.option[`SPOW_BIT_ONE_WIRE];
      tx_load  = 1'b0;
      tx_evt   = 1'b0;
      rx_evt   = 1'b0;
      stat_clr = 1'b0;
      sh_new   = state_ff.rx_sh;
      rx_data  = `SPOW_RST_BYTE;
      rx_ninth = 1'b0;
      rx_accept = 1'b0;

      // pin synchronisers; only the second stage is read
      nxt_state.txd_sync = {state_ff.txd_sync[0], pins_in.txd_i};
      nxt_state.rxd_sync = {state_ff.rxd_sync[0], pins_in.rxd_i};
      line_in = one_wire ? state_ff.txd_sync[1] : state_ff.rxd_sync[1];
      nxt_state.line_prev = line_in;

      // timers count at clock/2
      tick2 = state_ff.prescale;
      nxt_state.prescale = ~state_ff.prescale;
      t1_ovf = tick2 && (state_ff.t1_cnt == `SPOW_T1_TOP);
      t2_ovf = tick2 && (state_ff.t2_cnt == `SPOW_T2_TOP);
      if (tick2) begin
         nxt_state.t1_cnt = t1_ovf ? state_ff.t1_reload : state_ff.t1_cnt + 8'h01;
         nxt_state.t2_cnt = t2_ovf ? state_ff.t2_reload : state_ff.t2_cnt + 16'h0001;
         nxt_state.m2_half = ~state_ff.m2_half;
      end
      if (t1_ovf) begin
         nxt_state.t1_half = ~state_ff.t1_half;
      end
      // undoubled rates drop every other tick
      t1_16 = t1_ovf && (state_ff.baud_dbl || state_ff.t1_half);
      m2_16 = tick2 && (state_ff.baud_dbl || state_ff.m2_half);
      tx_tick = sel_tick(mode, state_ff.tx_clk_sel, m2_16, t2_ovf, t1_16);
      rx_tick = sel_tick(mode, state_ff.rx_clk_sel, m2_16, t2_ovf, t1_16);

      // register writes
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            `SPOW_ADR_PWR_BAUD: begin
               nxt_state.baud_dbl = bus_req.wdata[`SPOW_BIT_BAUD_DBL];
               nxt_state.pwr_low  = bus_req.wdata[3:0];
            end
            `SPOW_ADR_OPTION:    nxt_state.option = bus_req.wdata;
            `SPOW_ADR_CTRL:      nxt_state.ctrl = bus_req.wdata;
            `SPOW_ADR_DATA:      tx_load = 1'b1;
            `SPOW_ADR_T1_RELOAD: begin
               nxt_state.t1_reload = bus_req.wdata;
               nxt_state.t1_cnt = bus_req.wdata;
            end
            `SPOW_ADR_T2_CLKSEL: begin
               nxt_state.rx_clk_sel = bus_req.wdata[`SPOW_BIT_RX_CLK_SEL];
               nxt_state.tx_clk_sel = bus_req.wdata[`SPOW_BIT_TX_CLK_SEL];
            end
            `SPOW_ADR_T2_RLD_LO: nxt_state.t2_reload[7:0] = bus_req.wdata;
            `SPOW_ADR_T2_RLD_HI: begin
               nxt_state.t2_reload[15:8] = bus_req.wdata;
               nxt_state.t2_cnt = {bus_req.wdata, state_ff.t2_reload[7:0]};
            end
            `SPOW_ADR_IRQ_MASK:  nxt_state.irq_mask = bus_req.wdata[1:0];
            default: ;
         endcase
      end

      // register reads, answered next cycle; unmapped reads zero
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `SPOW_ADR_PWR_BAUD:
               nxt_state.rd_data = {state_ff.baud_dbl, 3'h0, state_ff.pwr_low};
            `SPOW_ADR_OPTION:    nxt_state.rd_data = state_ff.option;
            `SPOW_ADR_CTRL:      nxt_state.rd_data = state_ff.ctrl;
            `SPOW_ADR_DATA:      nxt_state.rd_data = state_ff.rx_buf;
            `SPOW_ADR_T1_RELOAD: nxt_state.rd_data = state_ff.t1_reload;
            `SPOW_ADR_T2_CLKSEL:
               nxt_state.rd_data = {2'h0, state_ff.rx_clk_sel, state_ff.tx_clk_sel, 4'h0};
            `SPOW_ADR_T2_RLD_LO: nxt_state.rd_data = state_ff.t2_reload[7:0];
            `SPOW_ADR_T2_RLD_HI: nxt_state.rd_data = state_ff.t2_reload[15:8];
            `SPOW_ADR_IRQ_STAT: begin
               nxt_state.rd_data = {6'h00, state_ff.irq_stat};
               stat_clr = 1'b1;
            end
            `SPOW_ADR_IRQ_MASK:  nxt_state.rd_data = {6'h00, state_ff.irq_mask};
            default: ;
         endcase
      end

      // transmitter; a write while busy is dropped so a frame is never torn
      unique case (state_ff.tx_st)
         TX_IDLE: begin
            if (tx_load && (mode != MODE_SHIFT)) begin
               nxt_state.tx_sh  = {state_ff.ctrl[`SPOW_BIT_TX_NINTH], bus_req.wdata};
               nxt_state.tx_bit = 4'h0;
               nxt_state.tx_sub = 4'h0;
               nxt_state.tx_st  = TX_START;
               nxt_state.pins.txd_o = 1'b0;
            end else if (tx_load && (state_ff.rx_st == RX_IDLE)) begin
               nxt_state.tx_sh  = {1'b0, bus_req.wdata};
               nxt_state.tx_bit = 4'h0;
               nxt_state.tx_st  = TX_SHIFT;
            end
         end
         TX_START, TX_DATA, TX_NINTH, TX_STOP: begin
            if (tx_tick) begin
               nxt_state.tx_sub = state_ff.tx_sub + 4'h1;
               if (state_ff.tx_sub == `SPOW_OVS_LAST) begin
                  nxt_state.tx_sub = 4'h0;
                  unique case (state_ff.tx_st)
                     TX_START: begin
                        nxt_state.tx_st = TX_DATA;
                        nxt_state.pins.txd_o = state_ff.tx_sh[0];
                     end
                     TX_DATA: begin
                        nxt_state.tx_sh = {1'b0, state_ff.tx_sh[8:1]};
                        nxt_state.tx_bit = state_ff.tx_bit + 4'h1;
                        nxt_state.pins.txd_o = state_ff.tx_sh[1];
                        if (state_ff.tx_bit == `SPOW_LAST_BIT) begin
                           if (mode9) begin
                              nxt_state.tx_st = TX_NINTH;
                           end else begin
                              nxt_state.tx_st = TX_STOP;
                              nxt_state.pins.txd_o = 1'b1;
                              tx_evt = 1'b1;
                           end
                        end
                     end
                     TX_NINTH: begin
                        nxt_state.tx_st = TX_STOP;
                        nxt_state.pins.txd_o = 1'b1;
                        tx_evt = 1'b1;
                     end
                     default: nxt_state.tx_st = TX_IDLE;
                  endcase
               end
            end
         end
         TX_SHIFT: begin
            // shift clock toggles every cycle: clock/2 bit rate
            if (state_ff.pins.txd_o) begin
               nxt_state.pins.txd_o = 1'b0;
               nxt_state.pins.rxd_o = state_ff.tx_sh[0];
            end else begin
               nxt_state.pins.txd_o = 1'b1;
               nxt_state.tx_sh  = {1'b0, state_ff.tx_sh[8:1]};
               nxt_state.tx_bit = state_ff.tx_bit + 4'h1;
               if (state_ff.tx_bit == `SPOW_LAST_BIT) begin
                  nxt_state.tx_st = TX_IDLE;
                  tx_evt = 1'b1;
               end
            end
         end
      endcase

      // receiver
      unique case (state_ff.rx_st)
         RX_IDLE: begin
            nxt_state.rx_sub = 4'h0;
            nxt_state.rx_bit = 4'h0;
            if (state_ff.ctrl[`SPOW_BIT_RX_EN]) begin
               if (mode == MODE_SHIFT) begin
                  if (!state_ff.ctrl[`SPOW_BIT_RX_DONE] && (state_ff.tx_st == TX_IDLE)) begin
                     nxt_state.rx_st = RX_SHIFT;
                  end
               end else if (state_ff.line_prev && !line_in &&
                            (!one_wire || (state_ff.tx_st == TX_IDLE))) begin
                  nxt_state.rx_st = RX_START;
               end
            end
         end
         RX_START, RX_DATA, RX_NINTH, RX_STOP: begin
            if (rx_tick) begin
               nxt_state.rx_sub = state_ff.rx_sub + 4'h1;
               if (state_ff.rx_sub == `SPOW_OVS_MID) begin
                  unique case (state_ff.rx_st)
                     RX_START: begin
                        if (line_in) begin
                           nxt_state.rx_st = RX_IDLE; // glitch, not a start bit
                        end
                     end
                     RX_DATA, RX_NINTH: begin
                        nxt_state.rx_sh = {line_in, state_ff.rx_sh[8:1]};
                     end
                     default: begin
                        // stop sample point
                        rx_data  = mode9 ? state_ff.rx_sh[7:0] : state_ff.rx_sh[8:1];
                        rx_ninth = mode9 ? state_ff.rx_sh[8] : line_in;
                        rx_accept = !state_ff.ctrl[`SPOW_BIT_RX_DONE] &&
                                    (!state_ff.ctrl[`SPOW_BIT_MPROC] || rx_ninth);
                        if (rx_accept) begin
                           nxt_state.rx_buf = rx_data;
                           nxt_state.ctrl[`SPOW_BIT_RX_NINTH] = rx_ninth;
                           rx_evt = 1'b1;
                        end
                        nxt_state.rx_st = RX_IDLE;
                     end
                  endcase
               end else if (state_ff.rx_sub == `SPOW_OVS_LAST) begin
                  nxt_state.rx_sub = 4'h0;
                  if (state_ff.rx_st == RX_START) begin
                     nxt_state.rx_st = RX_DATA;
                  end else if (state_ff.rx_st == RX_NINTH) begin
                     nxt_state.rx_st = RX_STOP;
                  end else if (state_ff.rx_st == RX_DATA) begin
                     nxt_state.rx_bit = state_ff.rx_bit + 4'h1;
                     if (state_ff.rx_bit == `SPOW_LAST_BIT) begin
                        nxt_state.rx_st = mode9 ? RX_NINTH : RX_STOP;
                     end
                  end
               end
            end
         end
         RX_SHIFT: begin
            // sample on the rising shift clock; pin is seen two cycles late
            if (state_ff.pins.txd_o) begin
               nxt_state.pins.txd_o = 1'b0;
            end else begin
               nxt_state.pins.txd_o = 1'b1;
               sh_new = {state_ff.rxd_sync[1], state_ff.rx_sh[8:1]};
               nxt_state.rx_sh  = sh_new;
               nxt_state.rx_bit = state_ff.rx_bit + 4'h1;
               if (state_ff.rx_bit == `SPOW_LAST_BIT) begin
                  nxt_state.rx_buf = sh_new[8:1];
                  nxt_state.rx_st  = RX_IDLE;
                  rx_evt = 1'b1;
               end
            end
         end
      endcase

      // pin enables: tx pin released when idle in single-pin mode, except in shift mode
      nxt_state.pins.txd_oe_n = one_wire && (mode != MODE_SHIFT) &&
                                (nxt_state.tx_st == TX_IDLE);
      nxt_state.pins.rxd_oe_n = (nxt_state.tx_st != TX_SHIFT);

      // flags: hardware set wins over a software write or a read-clear
      if (tx_evt) begin
         nxt_state.ctrl[`SPOW_BIT_TX_DONE] = 1'b1;
      end
      if (rx_evt) begin
         nxt_state.ctrl[`SPOW_BIT_RX_DONE] = 1'b1;
      end
      nxt_state.irq_stat = stat_clr ? 2'h0 : state_ff.irq_stat;
      nxt_state.irq_stat[`SPOW_IRQ_TX] = nxt_state.irq_stat[`SPOW_IRQ_TX] | tx_evt;
      nxt_state.irq_stat[`SPOW_IRQ_RX] = nxt_state.irq_stat[`SPOW_IRQ_RX] | rx_evt;
      nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);
   end

   // single state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= RESET_STATE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs straight from the state register
   assign rd_data  = state_ff.rd_data;
   assign irq      = state_ff.irq;
   assign pins_out = state_ff.pins;

endmodule

/* tb/spow_port_monitor.sv */
// Purpose: property checks on the serial port pins and register port
// Assumes: one clock domain, asynchronous active low reset
// Notes:   shadows follow software writes only
`timescale 1ns/100ps
module spow_port_monitor (
   input wire logic                        ref_clk,  // system clock
   input wire logic                        rst_n,    // reset, active low
   input wire spow_pkg::spow_bus_req_type  bus_req,  // register request
   input wire logic [7:0]                  rd_data,  // read data
   input wire logic                        irq,      // interrupt level
   input wire spow_pkg::spow_pins_in_type  pins_in,  // pin levels
   input wire spow_pkg::spow_pins_out_type pins_out  // pin drive and enables
);
   import spow_pkg::*;
   logic [7:0] ctrl_ff;
   logic [7:0] opt_ff;
   logic [7:0] mask_ff;
   // shadows of control, option and mask as written by software
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= 8'h00;
         opt_ff  <= 8'h00;
         mask_ff <= 8'h00;
      end else if (bus_req.wr) begin
         if (bus_req.addr == 8'h98) ctrl_ff <= bus_req.wdata;
         if (bus_req.addr == 8'h94) opt_ff <= bus_req.wdata;
         if (bus_req.addr == 8'hE1) mask_ff <= bus_req.wdata;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_rd_quiet: assert property (rd_data != 8'h00 |-> $past(bus_req.rd))
      else $error("read data outside a read answer");
   chk_unmapped_zero: assert property (bus_req.rd && !(bus_req.addr inside {8'h87, 8'h94,
      8'h98, 8'h99, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hE0, 8'hE1}) |=> rd_data == 8'h00)
      else $error("unmapped read returned data");
   chk_ctrl_readback: assert property (
      bus_req.rd && bus_req.addr == 8'h98 |=> rd_data[7:3] == ctrl_ff[7:3])
      else $error("control read differs from written value");
   chk_stat_upper: assert property (bus_req.rd && bus_req.addr == 8'hE0 |=> rd_data[7:2] == 6'h00)
      else $error("status read shows unused bits");
   chk_irq_masked: assert property (irq |-> mask_ff != 8'h00 || $past(mask_ff) != 8'h00)
      else $error("interrupt with every source masked");
   chk_rx_pin_shift: assert property (!pins_out.rxd_oe_n |-> ctrl_ff[7:6] == 2'h0)
      else $error("rx pin driven outside shift mode");
   chk_one_wire_rel: assert property (
      opt_ff[7] && ctrl_ff[7:6] != 2'h0 |-> pins_out.rxd_oe_n)
      else $error("rx pin driven in single-pin mode");
   chk_tx_pin_drive: assert property (!opt_ff[7] && !$past(opt_ff[7]) |-> !pins_out.txd_oe_n)
      else $error("tx pin released in two-pin mode");
   chk_shift_clk: assert property (
      !pins_out.rxd_oe_n && !$past(pins_out.rxd_oe_n) |-> pins_out.txd_o != $past(pins_out.txd_o))
      else $error("shift clock did not toggle");
   chk_shift_len: assert property ($fell(pins_out.rxd_oe_n) |-> (!pins_out.rxd_oe_n)[*8])
      else $error("shift transmit ended early");
   cover property ($rose(irq));
   cover property ($fell(pins_out.rxd_oe_n));
   cover property (opt_ff[7] && !pins_out.txd_oe_n);
endmodule

bind spow_serial_port spow_port_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n),
   .bus_req(bus_req), .rd_data(rd_data), .irq(irq), .pins_in(pins_in), .pins_out(pins_out));

/* tb/spow_remote_model.sv */
// Purpose: remote serial device on the far side of the port pins
// Assumes: bit time given in system clock periods of 10 ns
// Notes:   a released line rests high on its pull-up
`timescale 1ns/100ps
module spow_remote_model (
   input  wire logic line_in,  // line driven by the port
   output      logic line_out  // line driven by the remote
);
   initial line_out = 1'b1;
   // low start, data lsb first, then stop level as asked (a bad stop is allowed)
   task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bc);
      line_out = 1'b0;
      #(bc * 10);
      for (int i = 0; i < nb; i++) begin
         line_out = d[i];
         #(bc * 10);
      end
      line_out = stop;
      #(bc * 10);
      line_out = 1'b1;
   endtask
   // mid-bit sampling; bit nb holds the stop level, with no frame the idle line is sampled after the wait limit
   task automatic recv(output logic [9:0] d, input int nb, input int bc);
      int w;
      d = 10'h000;
      w = 0;
      while (line_in && w < 20000) begin
         #10;
         w++;
      end
      #(bc * 5);
      for (int i = 0; i <= nb; i++) begin
         #(bc * 10);
         d[i] = line_in;
      end
   endtask
endmodule

/* tb/spow_serial_port_test.sv */
// Purpose: self-checking bench of the serial port with single-pin option
// Assumes: 100 MHz clock, remote model wired to both pins
// Notes:   all-ones reloads keep frames short
`timescale 1ns/100ps
module spow_serial_port_test;
   import spow_pkg::*;
   logic              ref_clk;
   logic              rst_n;
   spow_bus_req_type  req;
   logic [7:0]        rd_data;
   logic              irq;
   spow_pins_in_type  pins_in;
   spow_pins_out_type pins_out;
   logic              one_wire;
   logic              rem_out;
   logic              txd_wire;
   int                miscompares;
   int                checked;
   logic [9:0]        got;
   // wired pins with pull-ups; the remote joins the tx pin only in single-pin mode
   assign txd_wire = (pins_out.txd_oe_n | pins_out.txd_o) & (!one_wire | rem_out);
   assign pins_in = {txd_wire, pins_out.rxd_oe_n ? (one_wire | rem_out) : pins_out.rxd_o};
   spow_serial_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req), .rd_data(rd_data),
      .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
   spow_remote_model rem (.line_in(txd_wire), .line_out(rem_out));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the read edge
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      @(negedge ref_clk);
      chk(what, {2'b00, rd_data}, {2'b00, exp});
   endtask
   task automatic irq_chk(input string what, input logic exp);
      repeat (2) @(negedge ref_clk);
      chk(what, {9'h000, irq}, {9'h000, exp});
   endtask
   task automatic t_regs();
      rchk("ctrl reset", 8'h98, 8'h00);
      rchk("option reset", 8'h94, 8'h00);
      rchk("unmapped", 8'h50, 8'h00);
   endtask
   // fixed-rate nine-bit transmit; flag and interrupt come at the stop bit
   task automatic t_tx9();
      wr(8'hE1, 8'h01);
      wr(8'h98, 8'h88);
      fork
         rem.recv(got, 9, 64);
         wr(8'h99, 8'hA5);
      join
      chk("nine-bit frame", got, 10'h3A5);
      irq_chk("tx irq", 1'b1);
      rchk("tx flag", 8'h98, 8'h8A);
      rchk("tx status", 8'hE0, 8'h01);
      rchk("status cleared", 8'hE0, 8'h00);
      irq_chk("tx irq cleared", 1'b0);
      wr(8'h98, 8'h88);
      rchk("rx buffer untouched", 8'h99, 8'h00);
      repeat (40) @(posedge ref_clk);
   endtask
   // timer2 clocked nine-bit receive with address filtering
   task automatic t_rx9();
      wr(8'hCA, 8'hFF);
      wr(8'hCB, 8'hFF);
      wr(8'hC8, 8'h20);
      wr(8'hE1, 8'h02);
      wr(8'h98, 8'hF0);
      rem.send(9'h05A, 9, 1'b1, 32);
      rchk("ninth zero dropped", 8'h98, 8'hF0);
      rem.send(9'h1C3, 9, 1'b1, 32);
      rchk("ninth one taken", 8'h98, 8'hF5);
      rchk("rx byte", 8'h99, 8'hC3);
      irq_chk("rx irq", 1'b1);
      wr(8'hE1, 8'h00);
      irq_chk("rx irq masked", 1'b0);
      rchk("rx status", 8'hE0, 8'h02);
   endtask
   // timer1 doubled eight-bit receive: stop check and receive enable
   task automatic t_rx8();
      wr(8'h8D, 8'hFF);
      wr(8'h87, 8'h80);
      wr(8'hC8, 8'h00);
      wr(8'h98, 8'h70);
      rem.send(9'h0E7, 8, 1'b0, 32);
      rchk("bad stop dropped", 8'h98, 8'h70);
      rem.send(9'h03C, 8, 1'b1, 32);
      rchk("good stop taken", 8'h98, 8'h75);
      rchk("doubled rate byte", 8'h99, 8'h3C);
      wr(8'h98, 8'h60);
      rem.send(9'h081, 8, 1'b1, 32);
      rchk("disabled no flag", 8'h98, 8'h60);
      rchk("disabled no data", 8'h99, 8'h3C);
   endtask
   // single pin carries both directions
   task automatic t_one_wire();
      wr(8'h94, 8'h80);
      one_wire = 1'b1;
      wr(8'h98, 8'h50);
      fork
         rem.recv(got, 8, 32);
         wr(8'h99, 8'h96);
      join
      chk("one-pin frame", got, 10'h196);
      repeat (40) @(posedge ref_clk);
      wr(8'h98, 8'h50);
      rem.send(9'h069, 8, 1'b1, 32);
      rchk("one-pin rx byte", 8'h99, 8'h69);
      rchk("one-pin rx flag", 8'h98, 8'h55);
   endtask
   // shift mode transmit, bits taken on the low phase of the shift clock
   task automatic t_shift();
      int         n;
      logic [7:0] rv;
      wr(8'h94, 8'h00);
      one_wire = 1'b0;
      wr(8'h98, 8'h00);
      wr(8'h99, 8'h6B);
      n = 0;
      rv = 8'h00;
      repeat (40) begin
         @(negedge ref_clk);
         if (!pins_out.rxd_oe_n && !pins_out.txd_o) begin
            rv = {pins_out.rxd_o, rv[7:1]};
            n++;
         end
      end
      chk("shift byte", {2'b00, rv}, 10'h06B);
      chk("shift clocks", {6'h00, n[3:0]}, 10'h008);
      rchk("shift tx flag", 8'h98, 8'h02);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      rst_n = 1'b0;
      req = '0;
      one_wire = 1'b0;
      miscompares = 0;
      checked = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_tx9();
      t_rx9();
      t_rx8();
      t_one_wire();
      t_shift();
      final_report();
   end
   // run is near 3200 cycles; 30000 means a hang
   initial begin
      repeat (30000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end
endmodule
